// ===== rtl/rcps_regs.vh
// Register map, field positions, reset values and timing constants of the room PWM/scene block
`ifndef RCPS_REGS_VH
`define RCPS_REGS_VH

// Timing
`define RCPS_CLK_NS       40
`define RCPS_TICK_NS      100000000
`define RCPS_TICK_W       22

// Byte offsets
`define RCPS_A_CTRL       8'h00
`define RCPS_A_SETPT      8'h04
`define RCPS_A_ACTUAL     8'h08
`define RCPS_A_BAND       8'h0c
`define RCPS_A_INTEG      8'h10
`define RCPS_A_PERIOD     8'h14
`define RCPS_A_THRESH     8'h18
`define RCPS_A_OPMODE     8'h1c
`define RCPS_A_SCENE      8'h20
`define RCPS_A_FANSEL     8'h24
`define RCPS_A_FANPCT     8'h28
`define RCPS_A_STATUS     8'h2c
`define RCPS_A_OUTDOOR    8'h30

// CTRL fields
`define RCPS_F_MODE       1:0
`define RCPS_F_COOL       2
`define RCPS_F_CORR       3
`define RCPS_F_FANPOL     4
`define RCPS_CTRL_W       5

// Control modes
`define RCPS_CM_SW        2'h0
`define RCPS_CM_P         2'h1
`define RCPS_CM_PI        2'h2

// Scene code classes, taken from code bits 7:6
`define RCPS_SC_RECALL    2'h0
`define RCPS_SC_SAVE      2'h2
`define RCPS_SC_IGNORE    2'h1

// Reset values
`define RCPS_RST_CTRL     5'h12
`define RCPS_RST_SETPT    16'h00d2
`define RCPS_RST_ACTUAL   16'h00d2
`define RCPS_RST_BAND     16'h0028
`define RCPS_RST_INTEG    16'h0064
`define RCPS_RST_PERIOD   16'h1770
`define RCPS_RST_THRESH   16'h0104
`define RCPS_RST_OUTDOOR  16'h00c8
`define RCPS_RST_FAN1     7'h14
`define RCPS_RST_FAN2     7'h32
`define RCPS_RST_FAN3     7'h50

// Percent scale
`define RCPS_FULL         7'h64

`endif

// ===== rtl/rcps_top.v
// Room controller output logic: PWM, P/PI control, setpoint correction, scenes, fan forcing
`timescale 1ns/10ps
`default_nettype none
`include "rcps_regs.vh"

module rcps_top #(
	parameter TICK_CYC = `RCPS_TICK_NS / `RCPS_CLK_NS
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        nrst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Bus objects in
	input  wire [7:0]  mode_scene_object,
	input  wire        mode_scene_stb,
	input  wire [15:0] outdoor_temp,
	input  wire        outdoor_stb,
	// Actuator objects out
	output reg         pwm_out,
	output reg  [6:0]  act_value,
	output reg  [1:0]  op_mode,
	output reg         fan_forced_obj,
	output reg  [6:0]  fan_stage_pct,
	output reg         fan_send
);

	localparam RD_IDLE = 2'h0;
	localparam RD_WAIT = 2'h1;
	localparam RD_DONE = 2'h2;
	localparam [31:0]             TICK_M1   = TICK_CYC - 1;
	localparam [`RCPS_TICK_W-1:0] TICK_LAST = TICK_M1[`RCPS_TICK_W-1:0];

	function [1:0] rcps_scene_kind;
		input [7:0] code;
		begin
			case (code[7:6])
				`RCPS_SC_RECALL: rcps_scene_kind = `RCPS_SC_RECALL;
				`RCPS_SC_SAVE:   rcps_scene_kind = `RCPS_SC_SAVE;
				default:         rcps_scene_kind = `RCPS_SC_IGNORE;
			endcase
		end
	endfunction

	// Write hit: a pending write whose data phase addresses the given offset
	function rcps_wr_hit;
		input       pend;
		input [7:0] addr;
		input [7:0] off;
		begin
			rcps_wr_hit = pend & (addr == off);
		end
	endfunction

	reg  [`RCPS_CTRL_W-1:0] ctrl_r;
	reg  [15:0]             setpt_r;
	reg  [15:0]             actual_r;
	reg  [15:0]             band_r;
	reg  [15:0]             integ_r;
	reg  [15:0]             period_r;
	reg  [15:0]             thresh_r;
	reg  [15:0]             outdoor_r;
	reg  [1:0]              fan_sel_r;
	reg  [6:0]              fan1_r;
	reg  [6:0]              fan2_r;
	reg  [6:0]              fan3_r;
	reg  [1:0]              scene_mem [0:63];
	reg  [1:0]              rd_st_r;
	reg  [7:0]              rd_addr_r;
	reg                     wr_pend_r;
	reg  [7:0]              wr_addr_r;
	reg  [`RCPS_TICK_W-1:0] tick_cnt_r;
	reg  [15:0]             pwm_cnt_r;
	reg  [15:0]             pwm_cnt_nxt;
	reg  [15:0]             integ_cnt_r;
	reg  [6:0]              integ_acc_r;
	reg  [6:0]              act_nxt;
	reg  [31:0]             rd_nxt;
	reg                     fan_wr_r;

	wire        addr_ok = hsel & htrans[1] & hready;
	wire        wr_go   = wr_pend_r;
	wire        tick    = (tick_cnt_r == TICK_LAST);
	wire [7:0]  sc_code = mode_scene_stb ? mode_scene_object : hwdata[7:0];
	wire        sc_stb  = mode_scene_stb | rcps_wr_hit(wr_go, wr_addr_r, `RCPS_A_SCENE);
	wire [1:0]  sc_kind = rcps_scene_kind(sc_code);
	wire [1:0]  cmode   = ctrl_r[`RCPS_F_MODE];
	wire        cool    = ctrl_r[`RCPS_F_COOL];

	// Setpoint correction, applied only while cooling
	wire signed [16:0] out_s  = {outdoor_r[15], outdoor_r};
	wire signed [16:0] thr_s  = {thresh_r[15], thresh_r};
	wire signed [16:0] sp_s   = {setpt_r[15], setpt_r};
	wire signed [16:0] act_s  = {actual_r[15], actual_r};
	wire               corr_on = cool & ctrl_r[`RCPS_F_CORR] & (out_s > thr_s);
	wire signed [16:0] sp_eff = corr_on ? (sp_s + (out_s - thr_s)) : sp_s;
	wire signed [16:0] dev    = cool ? (act_s - sp_eff) : (sp_eff - act_s);
	wire               dev_pos = (dev > 17'sd0);
	wire               dev_full = dev_pos & ({1'b0, dev[15:0]} >= {1'b0, band_r});
	wire [22:0]        p_num  = {7'h00, dev[15:0]} * {16'h0000, `RCPS_FULL};
	wire [22:0]        p_quo  = p_num / {7'h00, band_r};
	wire [6:0]         p_val  = !dev_pos ? 7'h00 : (dev_full ? `RCPS_FULL : p_quo[6:0]);
	wire [7:0]         pi_sum = {1'b0, p_val} + {1'b0, integ_acc_r};

	assign hreadyout = (rd_st_r != RD_WAIT);
	assign hresp     = 1'b0;

	// Bus interface: writes land one cycle after their address phase; reads take one wait
	// state so that a write in the preceding data phase is always seen
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_st_r   <= RD_IDLE;
			rd_addr_r <= 8'h00;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata    <= 32'h00000000;
		end
		else
		begin
			if (rd_st_r == RD_WAIT)
			begin
				hrdata  <= rd_nxt;
				rd_st_r <= RD_DONE;
			end
			else if (addr_ok & !hwrite)
			begin
				rd_st_r   <= RD_WAIT;
				rd_addr_r <= haddr[7:0];
			end
			else
				rd_st_r <= RD_IDLE;
			if (rd_st_r != RD_WAIT)
			begin
				wr_pend_r <= addr_ok & hwrite;
				wr_addr_r <= haddr[7:0];
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always @*
	begin
		rd_nxt = 32'h00000000;
		case (rd_addr_r)
			`RCPS_A_CTRL:    rd_nxt = {27'h0000000, ctrl_r};
			`RCPS_A_SETPT:   rd_nxt = {16'h0000, setpt_r};
			`RCPS_A_ACTUAL:  rd_nxt = {16'h0000, actual_r};
			`RCPS_A_BAND:    rd_nxt = {16'h0000, band_r};
			`RCPS_A_INTEG:   rd_nxt = {16'h0000, integ_r};
			`RCPS_A_PERIOD:  rd_nxt = {16'h0000, period_r};
			`RCPS_A_THRESH:  rd_nxt = {16'h0000, thresh_r};
			`RCPS_A_OPMODE:  rd_nxt = {30'h00000000, op_mode};
			`RCPS_A_FANSEL:  rd_nxt = {30'h00000000, fan_sel_r};
			`RCPS_A_FANPCT:  rd_nxt = {9'h000, fan3_r, 1'b0, fan2_r, 1'b0, fan1_r};
			`RCPS_A_STATUS:  rd_nxt = {sp_eff[15:0], 6'h00, fan_forced_obj, pwm_out,
				1'b0, act_value};
			`RCPS_A_OUTDOOR: rd_nxt = {16'h0000, outdoor_r};
			default:         rd_nxt = 32'h00000000;
		endcase
	end

	// Configuration registers
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_r    <= `RCPS_RST_CTRL;
			setpt_r   <= `RCPS_RST_SETPT;
			actual_r  <= `RCPS_RST_ACTUAL;
			band_r    <= `RCPS_RST_BAND;
			integ_r   <= `RCPS_RST_INTEG;
			period_r  <= `RCPS_RST_PERIOD;
			thresh_r  <= `RCPS_RST_THRESH;
			outdoor_r <= `RCPS_RST_OUTDOOR;
			fan_sel_r <= 2'h0;
			fan1_r    <= `RCPS_RST_FAN1;
			fan2_r    <= `RCPS_RST_FAN2;
			fan3_r    <= `RCPS_RST_FAN3;
		end
		else
		begin
			if (wr_go)
			begin
				case (wr_addr_r)
					`RCPS_A_CTRL:   ctrl_r   <= hwdata[`RCPS_CTRL_W-1:0];
					`RCPS_A_SETPT:  setpt_r  <= hwdata[15:0];
					`RCPS_A_ACTUAL: actual_r <= hwdata[15:0];
					`RCPS_A_BAND:   band_r   <= hwdata[15:0];
					`RCPS_A_INTEG:  integ_r  <= hwdata[15:0];
					`RCPS_A_PERIOD: period_r <= hwdata[15:0];
					`RCPS_A_THRESH: thresh_r <= hwdata[15:0];
					`RCPS_A_FANSEL: fan_sel_r <= hwdata[1:0];
					`RCPS_A_FANPCT:
					begin
						fan1_r <= hwdata[6:0];
						fan2_r <= hwdata[14:8];
						fan3_r <= hwdata[22:16];
					end
					default: ;
				endcase
			end
			// The outdoor object beats a software write in the same cycle
			if (outdoor_stb)
				outdoor_r <= outdoor_temp;
			else if (rcps_wr_hit(wr_go, wr_addr_r, `RCPS_A_OUTDOOR))
				outdoor_r <= hwdata[15:0];
		end
	end

	// Scene store; no reset so that a reset or reload of settings keeps the scenes
	always @(posedge core_clk)
	begin
		if (sc_stb & (sc_kind == `RCPS_SC_SAVE))
			scene_mem[sc_code[5:0]] <= op_mode;
	end

	// Operating mode; a scene recall wins over a direct write in the same cycle
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			op_mode <= 2'h0;
		else if (sc_stb & (sc_kind == `RCPS_SC_RECALL))
			op_mode <= scene_mem[sc_code[5:0]];
		else if (rcps_wr_hit(wr_go, wr_addr_r, `RCPS_A_OPMODE))
			op_mode <= hwdata[1:0];
		// Other codes fall through untouched
	end

	// Actuating value per control mode
	always @*
	begin
		act_nxt = 7'h00;
		case (cmode)
			`RCPS_CM_SW: act_nxt = dev_pos ? `RCPS_FULL : 7'h00;
			`RCPS_CM_P:  act_nxt = p_val;
			`RCPS_CM_PI: act_nxt = (pi_sum > {1'b0, `RCPS_FULL}) ? `RCPS_FULL : pi_sum[6:0];
			default:     act_nxt = 7'h00;
		endcase
	end

	// Time base and integral part; the integral holds once the setpoint is reached
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tick_cnt_r  <= {`RCPS_TICK_W{1'b0}};
			integ_cnt_r <= 16'h0000;
			integ_acc_r <= 7'h00;
			act_value   <= 7'h00;
		end
		else
		begin
			tick_cnt_r <= tick ? {`RCPS_TICK_W{1'b0}} : tick_cnt_r + 1'b1;
			act_value  <= act_nxt;
			if (cmode != `RCPS_CM_PI)
			begin
				integ_cnt_r <= 16'h0000;
				integ_acc_r <= 7'h00;
			end
			else if (tick)
			begin
				if (integ_cnt_r + 1'b1 >= integ_r)
				begin
					integ_cnt_r <= 16'h0000;
					if (dev_pos & (pi_sum < {1'b0, `RCPS_FULL}))
						integ_acc_r <= integ_acc_r + 1'b1;
				end
				else
					integ_cnt_r <= integ_cnt_r + 1'b1;
			end
		end
	end

	// PWM: the on time is recomputed every cycle from the live value, so a change acts
	// at once; comparing the phase with the new on time gives the owed extension, the
	// immediate cut-off or the earlier switch-off without extra state
	wire [22:0] on_prod = {7'h00, period_r} * {16'h0000, act_value};
	wire [22:0] on_time = on_prod / {16'h0000, `RCPS_FULL};

	// Phase counter; a period shortened below the phase restarts it at the next tick
	always @*
	begin
		pwm_cnt_nxt = pwm_cnt_r;
		if (tick)
		begin
			if (pwm_cnt_r + 1'b1 >= period_r)
				pwm_cnt_nxt = 16'h0000;
			else
				pwm_cnt_nxt = pwm_cnt_r + 1'b1;
		end
	end

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pwm_cnt_r <= 16'h0000;
			pwm_out   <= 1'b0;
		end
		else
		begin
			pwm_cnt_r <= pwm_cnt_nxt;
			// Full scale gives on_time equal to the period, so the output never drops
			pwm_out <= ({7'h00, pwm_cnt_r} < on_time);
		end
	end

	// Fan forcing objects, sent again whenever the stage choice is written
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fan_forced_obj <= 1'b0;
			fan_stage_pct  <= 7'h00;
			fan_send       <= 1'b0;
			fan_wr_r       <= 1'b0;
		end
		else
		begin
			// The stage objects settle one cycle after the write, so the send waits for them
			fan_wr_r <= rcps_wr_hit(wr_go, wr_addr_r, `RCPS_A_FANSEL);
			fan_send <= fan_wr_r;
			if (fan_sel_r != 2'h0)
				fan_forced_obj <= ctrl_r[`RCPS_F_FANPOL];
			else
				fan_forced_obj <= ~ctrl_r[`RCPS_F_FANPOL];
			case (fan_sel_r)
				2'h1:    fan_stage_pct <= fan1_r;
				2'h2:    fan_stage_pct <= fan2_r;
				2'h3:    fan_stage_pct <= fan3_r;
				default: fan_stage_pct <= 7'h00;
			endcase
		end
	end

endmodule // rcps_top
`default_nettype wire

// ===== tb/rcps_top_monitor.sv
// Port checker for the room PWM/scene block
`timescale 1ns/10ps
`default_nettype none
module rcps_monitor (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       nrst,
	// Register bus
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	// Objects
	input wire logic [7:0] mode_scene_object,
	input wire logic       mode_scene_stb,
	input wire logic       pwm_out,
	input wire logic [6:0] act_value,
	input wire logic [1:0] op_mode,
	input wire logic       fan_send
);
	// Shadow scene store, never reset, like the device's own
	logic [1:0] saved_r [0:63];
	logic [1:0] exp_r;
	wire        take = hsel && htrans[1] && hready;
	always @(posedge core_clk)
	begin
		if (mode_scene_stb && mode_scene_object[7:6] == 2'h2)
			saved_r[mode_scene_object[5:0]] <= op_mode;
		exp_r <= saved_r[mode_scene_object[5:0]];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_bus_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_zero_off: assert property (act_value == 7'h00 [*3] |=> !pwm_out)
		else $error("output on at zero value");
	a_full_on: assert property (act_value == 7'h64 [*3] |=> pwm_out)
		else $error("output off at full value");
	a_fan_pulse: assert property (fan_send |=> !fan_send)
		else $error("fan send longer than one cycle");
	a_scene_ignore: assert property (mode_scene_stb && mode_scene_object[6] |=>
		$stable(op_mode)) else $error("ignored scene code changed mode");
	a_recall_mode: assert property (mode_scene_stb && mode_scene_object[7:6] == 2'h0
		|=> op_mode == exp_r) else $error("recalled mode differs from saved");
endmodule // rcps_monitor
bind rcps_top rcps_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.mode_scene_object(mode_scene_object), .mode_scene_stb(mode_scene_stb),
	.pwm_out(pwm_out), .act_value(act_value), .op_mode(op_mode), .fan_send(fan_send));
`default_nettype wire

// ===== tb/rcps_bus_node.sv
// Building-bus sensor and fan actuator model
`timescale 1ns/10ps
`default_nettype none
module rcps_bus_node (
	// Clock
	input wire logic        core_clk,
	// Objects to the controller
	output logic [7:0]      mode_scene_object,
	output logic            mode_scene_stb,
	output logic [15:0]     outdoor_temp,
	output logic            outdoor_stb,
	// Fan objects from the controller
	input wire logic        fan_forced_obj,
	input wire logic [6:0]  fan_stage_pct,
	input wire logic        fan_send
);
	logic       fan_forced_r = 1'b0;
	logic [6:0] fan_pct_r = 7'h00;
	logic [1:0] fan_stage_r = 2'h0;
	// Actuator stage thresholds; a forced value must lie above them
	localparam logic [6:0] THR1 = 7'h0a;
	localparam logic [6:0] THR2 = 7'h28;
	localparam logic [6:0] THR3 = 7'h46;
	initial
	begin
		mode_scene_object = 8'h00;
		mode_scene_stb = 1'b0;
		outdoor_temp = 16'h0000;
		outdoor_stb = 1'b0;
	end
	// The actuator only takes what was sent
	always @(posedge core_clk)
		if (fan_send)
		begin
			fan_forced_r <= fan_forced_obj;
			fan_pct_r <= fan_stage_pct;
			fan_stage_r <= (fan_stage_pct > THR3) ? 2'h3 : (fan_stage_pct > THR2) ? 2'h2 :
				(fan_stage_pct > THR1) ? 2'h1 : 2'h0;
		end
	// Bits 5:0 scene, bits 7:6 recall or save; stale byte inverted after the strobe
	task automatic send_scene(input logic [7:0] code);
		mode_scene_object <= code;
		mode_scene_stb <= 1'b1;
		@(posedge core_clk);
		mode_scene_stb <= 1'b0;
		mode_scene_object <= ~code;
	endtask
	task automatic send_temp(input logic [15:0] t);
		outdoor_temp <= t;
		outdoor_stb <= 1'b1;
		@(posedge core_clk);
		outdoor_stb <= 1'b0;
		outdoor_temp <= ~t;
	endtask
endmodule // rcps_bus_node
`default_nettype wire

// ===== tb/tb_room_controller_pwm_scene.sv
// Self-checking bench for the room PWM/scene block
`timescale 1ns/10ps
`default_nettype none
module tb_room_controller_pwm_scene;
	logic        core_clk, nrst, hsel, hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, rd;
	wire         hreadyout, hresp, scn_stb, out_stb, pwm_out, fan_forced_obj, fan_send;
	wire  [31:0] hrdata;
	wire  [7:0]  scn_obj;
	wire  [15:0] out_temp;
	wire  [6:0]  act_value, fan_stage_pct;
	wire  [1:0]  op_mode;
	int          num_errors = 0, n_checks = 0, cyc = 0;
	rcps_top #(.TICK_CYC(4)) u_dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mode_scene_object(scn_obj), .mode_scene_stb(scn_stb), .outdoor_temp(out_temp),
		.outdoor_stb(out_stb), .pwm_out(pwm_out), .act_value(act_value), .op_mode(op_mode),
		.fan_forced_obj(fan_forced_obj), .fan_stage_pct(fan_stage_pct), .fan_send(fan_send));
	rcps_bus_node u_node (.core_clk(core_clk), .mode_scene_object(scn_obj),
		.mode_scene_stb(scn_stb), .outdoor_temp(out_temp), .outdoor_stb(out_stb),
		.fan_forced_obj(fan_forced_obj), .fan_stage_pct(fan_stage_pct), .fan_send(fan_send));
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One single word transfer; waits on hready, never on a cycle count
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Whole periods, so the phase does not matter, except the 76-cycle count, which starts just after a period begins
	task cnt_on(input int n, input int exp);
		int k;
		k = 0;
		repeat (n)
		begin
			@(posedge core_clk);
			k += (pwm_out === 1'b1);
		end
		chk(k, exp);
	endtask
	task pulse_rst;
		nrst <= 1'b0;
		wt(4);
		nrst <= 1'b1;
		wt(1);
	endtask
	task t_regs;
		xfer(0, 8'h00, 0);
		chk(rd, 32'h12);
		xfer(1, 8'h2c, 32'hffff);
		xfer(0, 8'h2c, 0);
		chk(rd, 32'h00d20000);
		xfer(0, 8'h3c, 0);
		chk(rd, 0);
		$display("test regs done");
	endtask
	task t_ctrl;
		xfer(1, 8'h14, 20);
		xfer(1, 8'h00, 32'h10);
		xfer(1, 8'h08, 200);
		wt(80);
		chk(act_value, 100);
		cnt_on(160, 160);
		xfer(1, 8'h00, 32'h11);
		wt(80);
		chk(act_value, 25);
		cnt_on(160, 40);
		chk(act_value, 25);
		xfer(1, 8'h08, 170);
		wt(4);
		chk(act_value, 100);
		xfer(1, 8'h08, 210);
		wt(4);
		chk(pwm_out, 0);
		cnt_on(160, 0);
		xfer(1, 8'h08, 170);
		wt(4);
		chk(pwm_out, 1);
		xfer(1, 8'h08, 190);
		do @(posedge core_clk); while (pwm_out !== 1'b0);
		do @(posedge core_clk); while (pwm_out !== 1'b1);
		xfer(1, 8'h08, 200);
		cnt_on(76, 17);
		xfer(1, 8'h10, 1);
		xfer(1, 8'h00, 32'h12);
		xfer(1, 8'h08, 200);
		wt(40);
		chk(act_value > 7'd25, 1);
		$display("test control done");
	endtask
	task t_corr;
		xfer(1, 8'h00, 32'h1d);
		xfer(1, 8'h08, 260);
		u_node.send_temp(300);
		wt(3);
		chk(act_value, 25);
		xfer(0, 8'h2c, 0);
		chk(rd[31:16], 250);
		u_node.send_temp(250);
		wt(3);
		chk(act_value, 100);
		$display("test correction done");
	endtask
	task t_scene;
		xfer(1, 8'h1c, 2);
		u_node.send_scene(8'h85);
		xfer(1, 8'h1c, 3);
		u_node.send_scene(8'hbf);
		xfer(1, 8'h1c, 1);
		u_node.send_scene(8'h45);
		wt(1);
		u_node.send_scene(8'hc5);
		wt(1);
		chk(op_mode, 1);
		pulse_rst;
		u_node.send_scene(8'h05);
		wt(1);
		chk(op_mode, 2);
		u_node.send_scene(8'h3f);
		wt(1);
		chk(op_mode, 3);
		$display("test scene done");
	endtask
	task t_fan;
		xfer(1, 8'h00, 32'h11);
		xfer(1, 8'h24, 2);
		wt(3);
		chk(u_node.fan_forced_r, 1);
		chk(u_node.fan_pct_r, 50);
		chk(u_node.fan_stage_r, 2);
		xfer(1, 8'h00, 32'h01);
		xfer(1, 8'h24, 3);
		wt(3);
		chk(u_node.fan_forced_r, 0);
		chk(u_node.fan_pct_r, 80);
		chk(u_node.fan_stage_r, 3);
		$display("test fan done");
	endtask
	task conclude;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			conclude;
		end
	end
	initial
	begin
		nrst = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		hsize = 3'h0;
		pulse_rst;
		t_regs;
		t_ctrl;
		t_corr;
		t_scene;
		t_fan;
		conclude;
	end
endmodule // tb_room_controller_pwm_scene
`default_nettype wire
